// ===== shared/evt_force_pkg.sv
package evt_force_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // register indices (req.addr carries the index itself, not a byte address)
   localparam logic [ADDR_W-1:0] SEL_IDX = 4'h0;
   localparam logic [ADDR_W-1:0] FLAG_IDX = 4'h1;
   localparam logic [ADDR_W-1:0] CLEAR_IDX = 4'h2;
   localparam logic [ADDR_W-1:0] FORCE_IDX = 4'h3;
   localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 4'h4;
   localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 4'h5;
   // field positions shared by selection, flag, clear and force registers
   localparam int INT_BIT = 0;
   localparam int CTA_BIT = 2;
   localparam int CTB_BIT = 3;
   localparam logic [DATA_W-1:0] FIELD_MASK = 16'h000d;
   localparam logic [DATA_W-1:0] SEL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] FLAG_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] MASK_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic cta;
      logic ctb;
      logic irq;
   } trig_out_t;
endpackage : evt_force_pkg

// ===== core/event_trigger_force_logic.sv
// Notes on behaviour
// R1: force bit 3 pulses trigger B only when B is enabled in selection.
// R2: force bit 3 always sets the B latched flag.
// R3: force bit 2 pulses trigger A only when A is enabled in selection.
// R4: force bit 2 always sets the A latched flag.
// R5: force bit 0 raises the interrupt only when enabled in selection.
// R6: force bit 0 always sets the interrupt latched flag.
// R7: writing 0 to a force bit does nothing; force bits read 0.
// R8: force bits 15..4 and 1 are reserved with no function.
// R9: software masks, initialises, clears stale flags, then unmasks, in that order.
// R10: while interrupt flag set, no new interrupt; one event held pending.
// R11: clear bit 0 write 1 clears interrupt flag; 0 ignored; reads 0.
// R12: conversion triggers keep pulsing while their flags remain set.
// R13: forced trigger pulse is one clock, same gate as natural event.
//
// The address-and-strobe port and the address map were left to the implementer.
module event_trigger_force_logic (
   input wire logic clk,
   input wire logic rstn,
   input wire evt_force_pkg::reg_req_t req,
   output evt_force_pkg::trig_out_t trig,
   output logic [evt_force_pkg::DATA_W-1:0] rdata,
   input wire logic int_event,
   input wire logic cta_event,
   input wire logic ctb_event,
   output logic irq
);
   import evt_force_pkg::*;

   logic [DATA_W-1:0] sel_q, sel_d;
   logic [DATA_W-1:0] flag_q, flag_d;
   logic [DATA_W-1:0] stat_q, stat_d;
   logic [DATA_W-1:0] mask_q, mask_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic pend_q, pend_d;
   trig_out_t trig_q, trig_d;
   logic frc_wr, clr_wr;
   logic int_ev, cta_ev, ctb_ev;
   logic int_fire;

   assign frc_wr = req.wr && req.addr == FORCE_IDX;
   assign clr_wr = req.wr && req.addr == CLEAR_IDX;

   // forced and natural events merge before gating; reserved force bits unused
   assign int_ev = int_event || (frc_wr && req.wdata[INT_BIT]); // [R5] [R7] [R8]
   assign cta_ev = cta_event || (frc_wr && req.wdata[CTA_BIT]); // [R3] [R13]
   assign ctb_ev = ctb_event || (frc_wr && req.wdata[CTB_BIT]); // [R1] [R13]

   // interrupt leaves only when enabled and flag clear (pending or new event)
   assign int_fire = sel_q[INT_BIT] && !flag_q[INT_BIT] && (int_ev || pend_q); // [R10]

   always_comb begin
      sel_d = sel_q;
      mask_d = mask_q;
      flag_d = flag_q;
      pend_d = pend_q;
      trig_d = '{cta: 1'b0, ctb: 1'b0, irq: 1'b0};
      if (req.wr && req.addr == SEL_IDX) begin
         sel_d = req.wdata & FIELD_MASK;
      end
      if (req.wr && req.addr == IRQ_MASK_IDX) begin
         mask_d = req.wdata & FIELD_MASK;
      end
      // clear first so a same-cycle event wins
      if (clr_wr) begin
         flag_d = flag_q & ~(req.wdata & FIELD_MASK); // [R11]
         if (req.wdata[INT_BIT]) begin
            pend_d = pend_q;
         end
      end
      trig_d.cta = cta_ev && sel_q[CTA_BIT]; // [R3] [R12] [R13]
      trig_d.ctb = ctb_ev && sel_q[CTB_BIT]; // [R1] [R12] [R13]
      if (cta_ev) begin
         flag_d[CTA_BIT] = 1'b1; // [R4]
      end
      if (ctb_ev) begin
         flag_d[CTB_BIT] = 1'b1; // [R2]
      end
      if (int_fire) begin
         trig_d.irq = 1'b1; // [R5]
         flag_d[INT_BIT] = 1'b1;
         pend_d = pend_q && int_ev;
      end else if (int_ev) begin
         flag_d[INT_BIT] = 1'b1; // [R6]
         if (flag_q[INT_BIT] && sel_q[INT_BIT]) begin
            pend_d = 1'b1; // [R10]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_q <= SEL_RESET;
         mask_q <= MASK_RESET;
         flag_q <= FLAG_RESET;
         pend_q <= 1'b0;
         trig_q <= '{cta: 1'b0, ctb: 1'b0, irq: 1'b0};
      end else begin
         sel_q <= sel_d;
         mask_q <= mask_d;
         flag_q <= flag_d;
         pend_q <= pend_d;
         trig_q <= trig_d;
      end
   end

   assign trig = trig_q;

   // sticky status: set by output events, cleared by reading, set wins
   always_comb begin
      stat_d = stat_q;
      if (req.rd && req.addr == IRQ_STAT_IDX) begin
         stat_d = '0;
      end
      if (trig_q.irq) begin
         stat_d[INT_BIT] = 1'b1;
      end
      if (trig_q.cta) begin
         stat_d[CTA_BIT] = 1'b1;
      end
      if (trig_q.ctb) begin
         stat_d[CTB_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_q <= FLAG_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   assign irq = |(stat_q & mask_q);

   // read port; clear and force read as zero
   always_comb begin
      rdata_d = '0;
      if (req.rd) begin
         unique case (req.addr)
            SEL_IDX: rdata_d = sel_q;
            FLAG_IDX: rdata_d = flag_q;
            CLEAR_IDX: rdata_d = '0; // [R11]
            FORCE_IDX: rdata_d = '0; // [R7]
            IRQ_STAT_IDX: rdata_d = stat_q;
            IRQ_MASK_IDX: rdata_d = mask_q;
            default: rdata_d = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   // single- and two-cycle building blocks for the multi-step properties
   sequence s_int_armed;
      flag_q[INT_BIT] && pend_q && sel_q[INT_BIT];
   endsequence

   sequence s_int_clear_quiet;
      clr_wr && req.wdata[INT_BIT] && !int_ev;
   endsequence

   sequence s_int_released;
      !flag_q[INT_BIT] ##1 trig.irq;
   endsequence

   sequence s_one_irq;
      trig.irq ##1 !trig.irq;
   endsequence

   sequence s_cta_forced;
      frc_wr && req.wdata[CTA_BIT] && sel_q[CTA_BIT];
   endsequence

   sequence s_ctb_forced;
      frc_wr && req.wdata[CTB_BIT] && sel_q[CTB_BIT];
   endsequence

   sequence s_one_cta;
      trig.cta ##1 !trig.cta;
   endsequence

   sequence s_one_ctb;
      trig.ctb ##1 !trig.ctb;
   endsequence

   // conversion trigger paths
   AST_FORCE_B_PULSE: assert property (@(posedge clk) disable iff (!rstn) // [R1]
      (frc_wr && req.wdata[CTB_BIT] && sel_q[CTB_BIT]) |=> trig.ctb)
      else $error("forced B not pulsed");

   AST_FORCE_B_GATED: assert property (@(posedge clk) disable iff (!rstn) // [R1]
      (!sel_q[CTB_BIT] || (!ctb_event && !(frc_wr && req.wdata[CTB_BIT]))) |=> !trig.ctb)
      else $error("B pulse without enabled event");

   AST_FORCE_B_FLAG: assert property (@(posedge clk) disable iff (!rstn) // [R2]
      (frc_wr && req.wdata[CTB_BIT]) |=> flag_q[CTB_BIT])
      else $error("B flag not set");

   AST_FORCE_A_PULSE: assert property (@(posedge clk) disable iff (!rstn) // [R3]
      (frc_wr && req.wdata[CTA_BIT]) |=> (trig.cta == $past(sel_q[CTA_BIT])))
      else $error("A pulse gating wrong");

   AST_FORCE_A_GATED: assert property (@(posedge clk) disable iff (!rstn) // [R3]
      (!sel_q[CTA_BIT] || !cta_ev) |=> !trig.cta)
      else $error("A pulse without enabled event");

   AST_FORCE_A_FLAG: assert property (@(posedge clk) disable iff (!rstn) // [R4]
      (frc_wr && req.wdata[CTA_BIT]) |=> flag_q[CTA_BIT])
      else $error("A flag not set");

   AST_A_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rstn) // [R13]
      (s_cta_forced ##1 !cta_ev) |-> s_one_cta)
      else $error("forced A pulse not one cycle");

   AST_B_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rstn) // [R13]
      (s_ctb_forced ##1 !ctb_ev) |-> s_one_ctb)
      else $error("forced B pulse not one cycle");

   AST_TRIG_REPEAT: assert property (@(posedge clk) disable iff (!rstn) // [R12]
      (flag_q[CTA_BIT] && sel_q[CTA_BIT] && cta_ev) |=> trig.cta)
      else $error("A blocked by flag");

   AST_TRIG_REPEAT_B: assert property (@(posedge clk) disable iff (!rstn) // [R12]
      (flag_q[CTB_BIT] && sel_q[CTB_BIT] && ctb_ev) |=> trig.ctb)
      else $error("B blocked by flag");

   // interrupt path and its single pending slot
   AST_FORCE_INT: assert property (@(posedge clk) disable iff (!rstn) // [R5]
      (frc_wr && req.wdata[INT_BIT] && sel_q[INT_BIT] && !flag_q[INT_BIT]) |=> trig.irq)
      else $error("forced interrupt missing");

   AST_INT_GATED: assert property (@(posedge clk) disable iff (!rstn) // [R5]
      !sel_q[INT_BIT] |=> !trig.irq)
      else $error("interrupt while disabled");

   AST_FORCE_INT_FLAG: assert property (@(posedge clk) disable iff (!rstn) // [R6]
      (frc_wr && req.wdata[INT_BIT]) |=> flag_q[INT_BIT])
      else $error("interrupt flag not set");

   AST_DISABLED_NO_PEND: assert property (@(posedge clk) disable iff (!rstn) // [R6]
      (int_ev && !sel_q[INT_BIT] && !pend_q) |=> (flag_q[INT_BIT] && !pend_q))
      else $error("disabled interrupt event handled wrongly");

   AST_INT_HELD: assert property (@(posedge clk) disable iff (!rstn) // [R10]
      flag_q[INT_BIT] |=> !trig.irq)
      else $error("interrupt while flag set");

   AST_PEND_ARM: assert property (@(posedge clk) disable iff (!rstn) // [R10]
      (int_ev && flag_q[INT_BIT] && sel_q[INT_BIT]) |=> pend_q)
      else $error("event during set flag not held pending");

   AST_PEND_RELEASE: assert property (@(posedge clk) disable iff (!rstn) // [R10] [R11]
      (s_int_armed ##0 s_int_clear_quiet) |=> s_int_released)
      else $error("pending interrupt not issued after clear");

   AST_PEND_SINGLE: assert property (@(posedge clk) disable iff (!rstn) // [R10]
      (s_int_armed ##0 s_int_clear_quiet ##1 !int_ev) |=> s_one_irq)
      else $error("more than one pending interrupt issued");

   AST_INT_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // [R11]
      (clr_wr && req.wdata[INT_BIT] && !int_ev && !pend_q) |=> !flag_q[INT_BIT])
      else $error("interrupt flag not cleared");

   AST_CLEAR_ZERO_IGNORED: assert property (@(posedge clk) disable iff (!rstn) // [R11]
      (clr_wr && (req.wdata & FIELD_MASK) == '0 && !int_event && !cta_event && !ctb_event
      && (flag_q[INT_BIT] || !pend_q)) |=> $stable(flag_q))
      else $error("clear write of zero changed flags");

   // register port and sticky status
   AST_FORCE_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn) // [R7]
      (req.rd && req.addr == FORCE_IDX) |=> rdata == '0)
      else $error("force reads nonzero");

   AST_RESERVED_QUIET: assert property (@(posedge clk) disable iff (!rstn) // [R7] [R8]
      (frc_wr && (req.wdata & FIELD_MASK) == '0 && !int_event && !cta_event && !ctb_event && !pend_q)
      |=> ($stable(flag_q) && !trig.cta && !trig.ctb && !trig.irq))
      else $error("idle force write had an effect");

   AST_CLEAR_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn) // [R11]
      (req.rd && req.addr == CLEAR_IDX) |=> rdata == '0)
      else $error("clear reads nonzero");

   AST_FLAG_READ: assert property (@(posedge clk) disable iff (!rstn) // [R2] [R4] [R6]
      (req.rd && req.addr == FLAG_IDX) |=> rdata == $past(flag_q))
      else $error("flag readback wrong");

   AST_STAT_STICKY: assert property (@(posedge clk) disable iff (!rstn) // [R5]
      trig.irq |=> stat_q[INT_BIT])
      else $error("interrupt status not set");

   AST_STAT_A: assert property (@(posedge clk) disable iff (!rstn) // [R3]
      trig.cta |=> stat_q[CTA_BIT])
      else $error("A status not set");

   AST_STAT_B: assert property (@(posedge clk) disable iff (!rstn) // [R1]
      trig.ctb |=> stat_q[CTB_BIT])
      else $error("B status not set");
endmodule : event_trigger_force_logic

// ===== testbench/trig_sink.sv
module trig_sink (
   input wire logic clk,
   input wire logic rstn,
   input wire evt_force_pkg::trig_out_t trig,
   output logic [7:0] n_a,
   output logic [7:0] n_b,
   output logic [7:0] n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // converter and expansion side: counts cycles each line is high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n_a <= 8'h00;
         n_b <= 8'h00;
         n_i <= 8'h00;
      end else begin
         n_a <= n_a + 8'(trig.cta);
         n_b <= n_b + 8'(trig.ctb);
         n_i <= n_i + 8'(trig.irq);
      end
   end
endmodule : trig_sink

// ===== testbench/event_trigger_force_logic_bench.sv
module event_trigger_force_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import evt_force_pkg::*;
   logic clk, rstn, irq, ev;
   reg_req_t req;
   trig_out_t trig;
   logic [15:0] rdata;
   logic [7:0] n_a, n_b, n_i;
   int failures = 0;
   int n_checks = 0;
   event_trigger_force_logic u_event_trigger_force_logic (.clk(clk), .rstn(rstn), .req(req), .trig(trig),
      .rdata(rdata), .int_event(ev), .cta_event(ev), .ctb_event(ev), .irq(irq));
   trig_sink u_trig_sink (.clk(clk), .rstn(rstn), .trig(trig), .n_a(n_a), .n_b(n_b), .n_i(n_i));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // strobe held n cycles gives n back-to-back accesses
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d, input int n);
      @(posedge clk);
      req <= '{a, d, w, !w};
      repeat (n) @(posedge clk);
      req <= '0;
   endtask : acc
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      acc(1'b0, a, 16'h0000, 1);
      #1 chk(nm, e, rdata);
   endtask : rd
   task automatic cnt(input logic [7:0] a, input logic [7:0] b, input logic [7:0] i);
      repeat (4) @(posedge clk);
      #1 chk("pulses a", {8'h00, a}, {8'h00, n_a});
      chk("pulses b", {8'h00, b}, {8'h00, n_b});
      chk("pulses irq", {8'h00, i}, {8'h00, n_i});
   endtask : cnt
   // natural event on all three lines for n cycles
   task automatic evt(input int n);
      @(posedge clk);
      ev <= 1'b1;
      repeat (n) @(posedge clk);
      ev <= 1'b0;
   endtask : evt
   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      #200000;
      failures++;
      test_done();
   end
   initial begin
      rstn = 1'b0;
      req = '0;
      ev = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(SEL_IDX, SEL_RESET, "sel reset");
      rd(FLAG_IDX, FLAG_RESET, "flag reset");
      rd(IRQ_MASK_IDX, MASK_RESET, "mask reset");
      acc(1'b1, IRQ_MASK_IDX, 16'h0000, 1);
      acc(1'b1, SEL_IDX, 16'h0000, 1);
      acc(1'b1, CLEAR_IDX, 16'h000d, 1);
      acc(1'b1, FORCE_IDX, 16'h0000, 1);
      acc(1'b1, FORCE_IDX, 16'hfff2, 1);
      rd(FLAG_IDX, 16'h0000, "flag after idle force");
      rd(FORCE_IDX, 16'h0000, "force readback");
      acc(1'b1, FORCE_IDX, 16'h000d, 1);
      cnt(8'd0, 8'd0, 8'd0);
      rd(FLAG_IDX, 16'h000d, "flag disabled force");
      acc(1'b1, CLEAR_IDX, 16'h000d, 1);
      acc(1'b0, IRQ_STAT_IDX, 16'h0000, 1);
      acc(1'b1, SEL_IDX, 16'h000d, 1);
      acc(1'b1, IRQ_MASK_IDX, 16'h000d, 1);
      acc(1'b1, FORCE_IDX, 16'h000c, 2);
      cnt(8'd2, 8'd2, 8'd0);
      chk("irq level", 16'h0001, {15'h0000, irq});
      acc(1'b1, FORCE_IDX, 16'h0001, 1);
      acc(1'b1, FORCE_IDX, 16'h0001, 1);
      cnt(8'd2, 8'd2, 8'd1);
      acc(1'b1, CLEAR_IDX, 16'h0000, 1);
      cnt(8'd2, 8'd2, 8'd1);
      acc(1'b1, CLEAR_IDX, 16'h0001, 1);
      cnt(8'd2, 8'd2, 8'd2);
      rd(CLEAR_IDX, 16'h0000, "clear readback");
      rd(FLAG_IDX, 16'h000d, "flag after pending");
      rd(IRQ_STAT_IDX, 16'h000d, "status sticky");
      chk("irq after status read", 16'h0000, {15'h0000, irq});
      evt(2);
      cnt(8'd4, 8'd4, 8'd2);
      acc(1'b1, CLEAR_IDX, 16'h0001, 1);
      cnt(8'd4, 8'd4, 8'd3);
      acc(1'b1, IRQ_MASK_IDX, 16'h0000, 1);
      rd(4'hf, UNMAPPED_READ, "unmapped read");
      chk("irq masked", 16'h0000, {15'h0000, irq});
      test_done();
   end
endmodule : event_trigger_force_logic_bench
